// *** hw/axis_position_counter_unit.sv ***
// per-axis position counters, soft limits, ring, speed profile and reset command
// Operation
// - each positive drive pulse adds one to the command position
// - each negative drive pulse subtracts one from the command position
// - encoder pulses are counted in a separate feedback position counter
// - feedback input is quadrature or separate up/down pulses, by setting
// - host may read and write both counters at any time except while busy after a reset, even driving
// - both counters are signed 32-bit two's complement
// - a host write loads the value directly; zero clears
// - a read command puts the chosen quantity in the low and high readback
// - speed reads zero when stopped and rises from start to drive speed
// - acceleration reads zero when stopped and rises toward its setting
// - positive and negative compare registers hold signed 32-bit soft limits
// - with ring enabled the compare value is the counters' maximum
// - ring enable applies to both counters of the axis together
// - soft limits are not applied while the ring is enabled
// - host selects command or feedback position for limit comparison
// - command word with only bit 15 set resets the unit
// - busy goes low within 875 ns of the reset write
// - start speed is 1 to 8000; pulse rate is value times multiple
// - slow stop decelerates to start speed and then ceases output
`timescale 1ns/1ps
`default_nettype none
module axis_position_counter_unit #(
    parameter int Multiple = 1,
    parameter int RateDiv  = axis_pos_pkg::CLK_HZ,
    parameter int AccTick  = axis_pos_pkg::ACC_TICK_CYCLES
) (
    // clock and reset
    input  wire logic                             clk_sys,
    input  wire logic                             rst_n,
    // command register
    input  wire logic                             cmdWrite,
    input  wire logic [15:0]                      cmdData,
    input  wire logic [axis_pos_pkg::POS_W-1:0]   wrData,
    // settings
    input  wire logic [axis_pos_pkg::SET_W-1:0]   startSpeedSetting,
    input  wire logic [axis_pos_pkg::SET_W-1:0]   driveSpeedSetting,
    input  wire logic [axis_pos_pkg::SET_W-1:0]   accelSetting,
    input  wire logic                             ringEnable,
    input  wire logic                             softLimitEnable,
    input  wire logic                             compareFeedback,
    input  wire logic                             encoderMode,
    // encoder pins
    input  wire logic                             encA,
    input  wire logic                             encB,
    // drive outputs
    output var  logic                             pulsePlus,
    output var  logic                             pulseMinus,
    output var  logic                             driving,
    // readback
    output var  logic [15:0]                      readbackLowWord,
    output var  logic [15:0]                      readbackHighWord,
    output var  logic                             busyActiveLowN
);
    import axis_pos_pkg::*;

    if (Multiple < 1 || Multiple > 500 || RateDiv < 2 || RateDiv >= (1 << 27) || AccTick < 1)
        $error("axis_position_counter_unit: parameter out of range");

    ////////////////////////////////////////////////////////////////////////////
    logic [1:0]         rstSync_q;
    logic               rstN;
    logic [1:0]         encSync1_q;
    logic [1:0]         encSync2_q;
    logic               fbUp;
    logic               fbDown;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) rstSync_q <= 2'b00;
        else rstSync_q <= {rstSync_q[0], 1'b1};
    end
    assign rstN = rstSync_q[1];

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            encSync1_q <= 2'b00;
            encSync2_q <= 2'b00;
        end else begin
            encSync1_q <= {encB, encA};
            encSync2_q <= encSync1_q;
        end
    end

    quad_updown_decoder u_dec (
        .clk_sys   (clk_sys),
        .rstN      (rstN),
        .mode      (encoderMode),
        .phaseA    (encSync2_q[0]),
        .phaseB    (encSync2_q[1]),
        .countUp   (fbUp),
        .countDown (fbDown)
    );

    ////////////////////////////////////////////////////////////////////////////
    // command decode and reset-busy
    logic [3:0]         busyCnt_q;
    logic               accept;
    logic               isReset;
    logic               clr;
    logic [7:0]         opCode;

    assign accept  = cmdWrite && busyActiveLowN;
    assign isReset = accept && cmdData == CMD_RESET;
    assign opCode  = (accept && cmdData[15:CMD_HIGH_LSB] == 8'h00)
                   ? cmdData[CMD_HIGH_LSB-1:CMD_CODE_LSB] : 8'h00;
    assign clr     = busyCnt_q != 4'h0;

    function automatic logic isOp(input logic [7:0] code, input logic [7:0] want);
        return code == want && want != 8'h00;
    endfunction

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) busyCnt_q <= 4'h0;
        else if (isReset) busyCnt_q <= 4'(BUSY_HOLD);
        else if (clr) busyCnt_q <= busyCnt_q - 4'h1;
    end
    assign busyActiveLowN = !clr;

    ////////////////////////////////////////////////////////////////////////////
    // position counters and compare registers
    logic [POS_W-1:0]   cmdPos_q;
    logic [POS_W-1:0]   fbPos_q;
    logic [POS_W-1:0]   limPos_q;
    logic [POS_W-1:0]   limNeg_q;
    logic [POS_W-1:0]   cmpPos;
    logic               softActive;
    logic               blockPlus;
    logic               blockMinus;
    logic               emitPlus;
    logic               emitMinus;

    // one step of a counter; limPos_q is the ring maximum
    function automatic logic [POS_W-1:0] stepPos(input logic [POS_W-1:0] v,
                                               input logic up, input logic ring,
                                               input logic [POS_W-1:0] maxV);
        if (up) return (ring && v == maxV) ? RST_POS : v + 32'h1;
        return (ring && v == RST_POS) ? maxV : v - 32'h1;
    endfunction

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) cmdPos_q <= RST_POS;
        else if (clr) cmdPos_q <= RST_POS;
        else if (isOp(opCode, CMD_LOAD_CMDPOS)) cmdPos_q <= wrData;
        else if (emitPlus) cmdPos_q <= stepPos(cmdPos_q, 1'b1, ringEnable, limPos_q);
        else if (emitMinus) cmdPos_q <= stepPos(cmdPos_q, 1'b0, ringEnable, limPos_q);
    end

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) fbPos_q <= RST_POS;
        else if (clr) fbPos_q <= RST_POS;
        else if (isOp(opCode, CMD_LOAD_FBPOS)) fbPos_q <= wrData;
        else if (fbUp) fbPos_q <= stepPos(fbPos_q, 1'b1, ringEnable, limPos_q);
        else if (fbDown) fbPos_q <= stepPos(fbPos_q, 1'b0, ringEnable, limPos_q);
    end

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            limPos_q <= RST_LIMPOS;
            limNeg_q <= RST_LIMNEG;
        end else if (clr) begin
            limPos_q <= RST_LIMPOS;
            limNeg_q <= RST_LIMNEG;
        end else begin
            if (isOp(opCode, CMD_LOAD_LIMPOS)) limPos_q <= wrData;
            if (isOp(opCode, CMD_LOAD_LIMNEG)) limNeg_q <= wrData;
        end
    end

    assign cmpPos     = compareFeedback ? fbPos_q : cmdPos_q;
    assign softActive = softLimitEnable && !ringEnable;
    assign blockPlus  = softActive && $signed(cmpPos) >= $signed(limPos_q);
    assign blockMinus = softActive && $signed(cmpPos) <= $signed(limNeg_q);

    ////////////////////////////////////////////////////////////////////////////
    // speed profile
    drive_state_t       state_q;
    logic               dirNeg_q;
    logic [SPEED_W-1:0] curSpeed_q;
    logic [SET_W-1:0]   curAccel_q;
    logic [31:0]        tickCnt_q;
    logic               tick;
    logic               running;
    logic               hitLimit;
    logic [SPEED_W-1:0] speedUp;
    logic [SET_W-1:0]   accelUp;

    assign running  = state_q != S_IDLE;
    assign hitLimit = running && (dirNeg_q ? blockMinus : blockPlus);
    assign tick     = tickCnt_q == 32'(AccTick - 1);
    assign accelUp  = (curAccel_q < accelSetting) ? curAccel_q + 13'h1 : accelSetting;
    assign speedUp  = curSpeed_q + SPEED_W'(accelUp);

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) tickCnt_q <= 32'h0;
        else if (!running || tick) tickCnt_q <= 32'h0;
        else tickCnt_q <= tickCnt_q + 32'h1;
    end

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            state_q    <= S_IDLE;
            dirNeg_q   <= 1'b0;
            curSpeed_q <= 16'h0000;
            curAccel_q <= 13'h0000;
        end else if (clr || hitLimit || isOp(opCode, CMD_STOP_NOW)) begin
            state_q    <= S_IDLE;
            curSpeed_q <= 16'h0000;
            curAccel_q <= 13'h0000;
        end else begin
            case (state_q)
                S_IDLE: begin
                    curSpeed_q <= 16'h0000;
                    curAccel_q <= 13'h0000;
                    if (isOp(opCode, CMD_DRIVE_POS) || isOp(opCode, CMD_DRIVE_NEG)) begin
                        dirNeg_q   <= isOp(opCode, CMD_DRIVE_NEG);
                        curSpeed_q <= SPEED_W'(startSpeedSetting);
                        state_q    <= (driveSpeedSetting > startSpeedSetting) ? S_ACCEL : S_CONST;
                    end
                end
                S_ACCEL: begin
                    if (isOp(opCode, CMD_STOP_SLOW)) begin
                        state_q <= S_DECEL;
                    end else if (tick) begin
                        curAccel_q <= accelUp;
                        if (speedUp >= SPEED_W'(driveSpeedSetting)) begin
                            curSpeed_q <= SPEED_W'(driveSpeedSetting);
                            curAccel_q <= 13'h0000;
                            state_q    <= S_CONST;
                        end else begin
                            curSpeed_q <= speedUp;
                        end
                    end
                end
                S_CONST: begin
                    if (isOp(opCode, CMD_STOP_SLOW)) state_q <= S_DECEL;
                end
                S_DECEL: begin
                    curAccel_q <= accelSetting;
                    if (tick) begin
                        if (curSpeed_q <= SPEED_W'(startSpeedSetting)) begin
                            state_q    <= S_IDLE;
                            curSpeed_q <= 16'h0000;
                            curAccel_q <= 13'h0000;
                        end else if (curSpeed_q - SPEED_W'(accelSetting)
                                     < SPEED_W'(startSpeedSetting)
                                     || curSpeed_q < SPEED_W'(accelSetting)) begin
                            curSpeed_q <= SPEED_W'(startSpeedSetting);
                        end else begin
                            curSpeed_q <= curSpeed_q - SPEED_W'(accelSetting);
                        end
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end
    assign driving = running;

    ////////////////////////////////////////////////////////////////////////////
    // pulse rate generator: rate = speed * Multiple pulses per second
    logic [27:0]        phase_q;
    logic [28:0]        phaseSum;
    logic               emit;

    assign phaseSum  = 29'(phase_q) + 29'(curSpeed_q * Multiple);
    assign emit      = running && !clr && !hitLimit && phaseSum >= 29'(RateDiv);
    assign emitPlus  = emit && !dirNeg_q;
    assign emitMinus = emit && dirNeg_q;

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) phase_q <= 28'h0;
        else if (!running) phase_q <= 28'h0;
        else if (emit) phase_q <= 28'(phaseSum - 29'(RateDiv));
        else phase_q <= 28'(phaseSum);
    end

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            pulsePlus  <= 1'b0;
            pulseMinus <= 1'b0;
        end else begin
            pulsePlus  <= emitPlus;
            pulseMinus <= emitMinus;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // readback
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) {readbackHighWord, readbackLowWord} <= RST_POS;
        else if (clr) {readbackHighWord, readbackLowWord} <= RST_POS;
        else if (isOp(opCode, CMD_READ_CMDPOS))
            {readbackHighWord, readbackLowWord} <= cmdPos_q;
        else if (isOp(opCode, CMD_READ_FBPOS))
            {readbackHighWord, readbackLowWord} <= fbPos_q;
        else if (isOp(opCode, CMD_READ_SPEED))
            {readbackHighWord, readbackLowWord} <= 32'(curSpeed_q);
        else if (isOp(opCode, CMD_READ_ACCEL))
            {readbackHighWord, readbackLowWord} <= 32'(curAccel_q);
    end

    ////////////////////////////////////////////////////////////////////////////
    localparam int BusyBound = BUSY_MAX_CYCLES;

    property p_cmdUp;
        @(posedge clk_sys) disable iff (!rstN)
        $rose(pulsePlus) && !$past(ringEnable) && !$past(clr) && $past(opCode) == 8'h00
        |-> cmdPos_q == $past(cmdPos_q) + 32'h1;
    endproperty
    a_cmdUp: assert property (p_cmdUp) else $error("up pulse did not add one");

    property p_cmdDown;
        @(posedge clk_sys) disable iff (!rstN)
        $rose(pulseMinus) && !$past(ringEnable) && !$past(clr) && $past(opCode) == 8'h00
        |-> cmdPos_q == $past(cmdPos_q) - 32'h1;
    endproperty
    a_cmdDown: assert property (p_cmdDown) else $error("down pulse did not subtract one");

    property p_fbCount;
        @(posedge clk_sys) disable iff (!rstN)
        fbUp && !ringEnable && !clr && opCode == 8'h00
        |=> fbPos_q == $past(fbPos_q) + 32'h1;
    endproperty
    a_fbCount: assert property (p_fbCount) else $error("feedback count missed");

    property p_load;
        @(posedge clk_sys) disable iff (!rstN)
        isOp(opCode, CMD_LOAD_CMDPOS) |=> cmdPos_q == $past(wrData);
    endproperty
    a_load: assert property (p_load) else $error("position load failed");

    property p_idleSpeed;
        @(posedge clk_sys) disable iff (!rstN)
        !running && isOp(opCode, CMD_READ_SPEED) |=> {readbackHighWord, readbackLowWord} == 32'h0;
    endproperty
    a_idleSpeed: assert property (p_idleSpeed) else $error("stopped speed not zero");

    property p_idleAccel;
        @(posedge clk_sys) disable iff (!rstN)
        !running && isOp(opCode, CMD_READ_ACCEL) |=> {readbackHighWord, readbackLowWord} == 32'h0;
    endproperty
    a_idleAccel: assert property (p_idleAccel) else $error("stopped accel not zero");

    property p_wrap;
        @(posedge clk_sys) disable iff (!rstN)
        emitPlus && ringEnable && cmdPos_q == limPos_q && !clr && opCode == 8'h00
        |=> cmdPos_q == 32'h0 ##0 pulsePlus;
    endproperty
    a_wrap: assert property (p_wrap) else $error("ring did not wrap to zero");

    property p_noLimitInRing;
        @(posedge clk_sys) disable iff (!rstN)
        ringEnable |-> !blockPlus && !blockMinus;
    endproperty
    a_noLimitInRing: assert property (p_noLimitInRing) else $error("limit active in ring");

    property p_block;
        @(posedge clk_sys) disable iff (!rstN)
        running && !dirNeg_q && blockPlus |=> !pulsePlus && !running;
    endproperty
    a_block: assert property (p_block) else $error("pulse past positive limit");

    property p_busy;
        @(posedge clk_sys) disable iff (!rstN)
        isReset |-> ##[1:BusyBound] !busyActiveLowN;
    endproperty
    a_busy: assert property (p_busy) else $error("busy not low after reset write");

    property p_slowStop;
        @(posedge clk_sys) disable iff (!rstN)
        state_q == S_DECEL ##1 state_q == S_IDLE && !$past(clr) && !$past(hitLimit)
        && !$past(isOp(opCode, CMD_STOP_NOW))
        |-> $past(curSpeed_q) <= SPEED_W'($past(startSpeedSetting));
    endproperty
    a_slowStop: assert property (p_slowStop) else $error("stopped above start speed");

    c_const: cover property (@(posedge clk_sys) disable iff (!rstN)
        state_q == S_ACCEL ##1 state_q == S_CONST);
    c_slow: cover property (@(posedge clk_sys) disable iff (!rstN)
        state_q == S_DECEL ##1 state_q == S_IDLE);
    c_reset: cover property (@(posedge clk_sys) disable iff (!rstN) isReset);
    c_limit: cover property (@(posedge clk_sys) disable iff (!rstN) hitLimit);

endmodule // axis_position_counter_unit
`default_nettype wire

// *** hw/axis_pos_pkg.sv ***
// constants shared by the axis position counter unit
package axis_pos_pkg;

    // widths
    localparam int POS_W   = 32;
    localparam int SET_W   = 13;
    localparam int SPEED_W = 16;

    // command register codes
    localparam logic [15:0] CMD_RESET       = 16'h8000;
    localparam logic [7:0]  CMD_LOAD_CMDPOS = 8'h01;
    localparam logic [7:0]  CMD_LOAD_FBPOS  = 8'h02;
    localparam logic [7:0]  CMD_LOAD_LIMPOS = 8'h03;
    localparam logic [7:0]  CMD_LOAD_LIMNEG = 8'h04;
    localparam logic [7:0]  CMD_READ_CMDPOS = 8'h10;
    localparam logic [7:0]  CMD_READ_FBPOS  = 8'h11;
    localparam logic [7:0]  CMD_READ_SPEED  = 8'h12;
    localparam logic [7:0]  CMD_READ_ACCEL  = 8'h13;
    localparam logic [7:0]  CMD_DRIVE_POS   = 8'h20;
    localparam logic [7:0]  CMD_DRIVE_NEG   = 8'h21;
    localparam logic [7:0]  CMD_STOP_SLOW   = 8'h26;
    localparam logic [7:0]  CMD_STOP_NOW    = 8'h27;

    // field positions inside the command word
    localparam int CMD_CODE_LSB = 0;
    localparam int CMD_HIGH_LSB = 8;

    // feedback input formats
    localparam logic ENC_QUAD   = 1'b0;
    localparam logic ENC_UPDOWN = 1'b1;

    // reset values
    localparam logic [31:0] RST_POS    = 32'h0000_0000;
    localparam logic [31:0] RST_LIMPOS = 32'h7FFF_FFFF;
    localparam logic [31:0] RST_LIMNEG = 32'h8000_0000;

    // timing
    localparam int CLK_HZ          = 50_000_000;
    localparam int CLK_PERIOD_NS   = 20;
    localparam int BUSY_MAX_NS     = 875;
    localparam int BUSY_MAX_CYCLES = BUSY_MAX_NS / CLK_PERIOD_NS;
    localparam int BUSY_HOLD       = 8;
    localparam int ACC_TICK_HZ     = 125;
    localparam int ACC_TICK_CYCLES = CLK_HZ / ACC_TICK_HZ;

    // drive profile states
    typedef enum logic [3:0] {
        S_IDLE  = 4'b0001,
        S_ACCEL = 4'b0010,
        S_CONST = 4'b0100,
        S_DECEL = 4'b1000
    } drive_state_t;

endpackage

// *** hw/quad_updown_decoder.sv ***
// feedback input decoder: quadrature or separate up/down pulses
`timescale 1ns/1ps
`default_nettype none
module quad_updown_decoder (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rstN,
    // format select
    input  wire logic mode,
    // synchronised inputs
    input  wire logic phaseA,
    input  wire logic phaseB,
    // count events
    output var  logic countUp,
    output var  logic countDown
);
    import axis_pos_pkg::*;

    logic prevA_q;
    logic prevB_q;
    logic quadStep;
    logic quadUp;

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            prevA_q <= 1'b0;
            prevB_q <= 1'b0;
        end else begin
            prevA_q <= phaseA;
            prevB_q <= phaseB;
        end
    end

    // every edge counts; A leading B is the up direction
    assign quadStep = phaseA ^ prevA_q ^ phaseB ^ prevB_q;
    assign quadUp   = phaseA ^ prevB_q;

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            countUp   <= 1'b0;
            countDown <= 1'b0;
        end else if (mode == ENC_QUAD) begin
            countUp   <= quadStep & quadUp;
            countDown <= quadStep & ~quadUp;
        end else begin
            countUp   <= phaseA & ~prevA_q;
            countDown <= phaseB & ~prevB_q;
        end
    end
endmodule // quad_updown_decoder
`default_nettype wire

// *** dv/enc_model.sv ***
// encoder partner model: quadrature or up/down pulse source
`timescale 1ns/1ps
`default_nettype none
module enc_model (
    // clock and format
    input  wire logic clk_sys,
    input  wire logic mode,
    // encoder pins
    output var  logic encA,
    output var  logic encB
);
    initial begin
        encA = 1'b0;
        encB = 1'b0;
    end
    // one count; each level is held long enough to pass the synchroniser
    task automatic step(input logic up);
        @(posedge clk_sys);
        if (mode == 1'b0) begin
            if ((encA ^ encB) == up) encB <= ~encB;
            else encA <= ~encA;
        end else begin
            if (up) encA <= 1'b1;
            else encB <= 1'b1;
            repeat (4) @(posedge clk_sys);
            encA <= 1'b0;
            encB <= 1'b0;
        end
        repeat (4) @(posedge clk_sys);
    endtask
endmodule // enc_model
`default_nettype wire

// *** dv/axis_position_counter_unit_tb.sv ***
// self-checking bench for the axis position counter unit
`timescale 1ns/1ps
`default_nettype none
module axis_position_counter_unit_tb;
    import axis_pos_pkg::*;
    logic clk_sys = 0, rst_n = 0, cmdWrite = 0, ringEnable = 0, softLimitEnable = 0;
    logic compareFeedback = 0, encoderMode = 0, encA, encB;
    logic [15:0] cmdData = 0, readbackLowWord, readbackHighWord;
    logic [31:0] wrData = 0, rd;
    logic [SET_W-1:0] sv = 13'h000A, dv = 13'h0014, acc = 13'h0002;
    logic pulsePlus, pulseMinus, driving, busyActiveLowN;
    int bad_count = 0, n_compared = 0, nPlus = 0, nMinus = 0, i;
    always #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (pulsePlus === 1'b1) nPlus++;
    always @(posedge clk_sys) if (pulseMinus === 1'b1) nMinus++;
    axis_position_counter_unit #(.Multiple(1), .RateDiv(100), .AccTick(4))
    axis_position_counter_unit_i (.clk_sys(clk_sys), .rst_n(rst_n), .cmdWrite(cmdWrite),
        .cmdData(cmdData), .wrData(wrData), .startSpeedSetting(sv),
        .driveSpeedSetting(dv), .accelSetting(acc), .ringEnable(ringEnable),
        .softLimitEnable(softLimitEnable), .compareFeedback(compareFeedback),
        .encoderMode(encoderMode), .encA(encA), .encB(encB), .pulsePlus(pulsePlus),
        .pulseMinus(pulseMinus), .driving(driving), .readbackLowWord(readbackLowWord),
        .readbackHighWord(readbackHighWord), .busyActiveLowN(busyActiveLowN));
    enc_model enc_model_i (.clk_sys(clk_sys), .mode(encoderMode), .encA(encA), .encB(encB));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] c, input logic [31:0] d);
        @(posedge clk_sys);
        cmdWrite <= 1'b1;
        cmdData <= {8'h00, c};
        wrData <= d;
        @(posedge clk_sys);
        cmdWrite <= 1'b0;
        #1 rd = {readbackHighWord, readbackLowWord};
    endtask
    task automatic wait_idle();
        for (i = 0; i < 400 && driving !== 1'b0; i++) @(negedge clk_sys);
    endtask
    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_load_read();
        cmd(CMD_LOAD_CMDPOS, 32'h8000_0000);
        cmd(CMD_READ_CMDPOS, 0);
        check(rd, 32'h8000_0000);
        cmd(CMD_LOAD_CMDPOS, 0);
        cmd(CMD_READ_CMDPOS, 0);
        check(rd, 0);
        cmd(CMD_READ_SPEED, 0);
        check(rd, 0);
        cmd(CMD_READ_ACCEL, 0);
        check(rd, 0);
    endtask
    task automatic t_drive();
        cmd(CMD_DRIVE_POS, 0);
        cmd(CMD_READ_SPEED, 0);
        check(rd, {19'h0, sv});
        repeat (100) @(posedge clk_sys);
        cmd(CMD_READ_SPEED, 0);
        check(rd, {19'h0, dv});
        cmd(CMD_READ_CMDPOS, 0);
        check(rd, nPlus);
        cmd(CMD_STOP_SLOW, 0);
        check({31'h0, driving}, 1);
        wait_idle();
        cmd(CMD_READ_SPEED, 0);
        check(rd, 0);
        cmd(CMD_READ_CMDPOS, 0);
        check(rd, nPlus);
        cmd(CMD_DRIVE_NEG, 0);
        repeat (30) @(posedge clk_sys);
        cmd(CMD_STOP_NOW, 0);
        repeat (3) @(posedge clk_sys);
        cmd(CMD_READ_CMDPOS, 0);
        check({31'h0, nMinus > 0}, 1);
        check(rd, nPlus - nMinus);
    endtask
    task automatic t_encoder();
        cmd(CMD_LOAD_FBPOS, 0);
        repeat (4) enc_model_i.step(1'b1);
        cmd(CMD_READ_FBPOS, 0);
        check(rd, 4);
        encoderMode <= ENC_UPDOWN;
        repeat (2) enc_model_i.step(1'b0);
        cmd(CMD_READ_FBPOS, 0);
        check(rd, 2);
    endtask
    task automatic t_limit_ring();
        cmd(CMD_LOAD_LIMPOS, 3);
        cmd(CMD_LOAD_CMDPOS, 0);
        softLimitEnable <= 1'b1;
        cmd(CMD_DRIVE_POS, 0);
        wait_idle();
        cmd(CMD_READ_CMDPOS, 0);
        check(rd, 3);
        compareFeedback <= 1'b1;
        cmd(CMD_DRIVE_POS, 0);
        repeat (2) @(negedge clk_sys);
        check({31'h0, driving}, 1);
        cmd(CMD_STOP_NOW, 0);
        compareFeedback <= 1'b0;
        cmd(CMD_DRIVE_NEG, 0);
        repeat (2) @(negedge clk_sys);
        check({31'h0, driving}, 1);
        cmd(CMD_STOP_NOW, 0);
        ringEnable <= 1'b1;
        cmd(CMD_LOAD_CMDPOS, 2);
        nPlus = 0;
        cmd(CMD_DRIVE_POS, 0);
        for (i = 0; i < 400 && nPlus < 5; i++) @(posedge clk_sys);
        cmd(CMD_STOP_NOW, 0);
        repeat (3) @(posedge clk_sys);
        cmd(CMD_READ_CMDPOS, 0);
        check(rd, (2 + nPlus) % 4);
    endtask
    task automatic t_reset();
        @(posedge clk_sys);
        cmdWrite <= 1'b1;
        cmdData <= CMD_RESET;
        @(posedge clk_sys);
        cmdWrite <= 1'b0;
        for (i = 0; i < BUSY_MAX_CYCLES && busyActiveLowN !== 1'b0; i++) @(negedge clk_sys);
        check({31'h0, busyActiveLowN}, 0);
        for (i = 0; i < 40 && busyActiveLowN !== 1'b1; i++) @(negedge clk_sys);
        cmd(CMD_READ_CMDPOS, 0);
        check(rd, 0);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_load_read();
        t_drive();
        t_encoder();
        t_limit_ring();
        t_reset();
        wrap_up();
    end
    initial begin
        #400000;
        bad_count++;
        wrap_up();
    end
endmodule // axis_position_counter_unit_tb
`default_nettype wire
